// ==== rtl/pbcu_top.sv ====
// How it works
// - Latched-high bit sets on its event and holds one until read.
// - Latched-low bit clears on its event and holds zero until read.
// - Self-clearing bit sets on event or write, clears when operation completes; bit 15 here sets on write only.
// - Strap bits load from sampled pin; undriven pin reads pull level.
// - Writing one to bit 15 returns control bits to defaults.
// - Bit 15 reads one during soft reset, about 1.2 ms, then clears.
// - Soft reset ends on autoneg restart or forced mode entry.
// - Loopback bit 14 routes MAC transmit data back to receive.
// - Loopback turns at converter, bypassing line; resets to zero.
// - Forced speed code: 10 is 1000, 01 is 100, 00 is 10.
// - Bit 13 defaults from strap and stays writable.
// - With autoneg enabled, bits 6, 8 and 13 are ignored.
// - With autoneg disabled, bits 6, 8, 13 set speed and duplex.
// - Autoneg enable defaults from pulled-up strap, writable afterwards.
// - Bit 8 selects full (1) or half (0) duplex.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pbcu_top #(
    parameter int SOFT_RESET_LEN = pbcu_pkg::SOFT_RESET_CYCLES
) (
    input wire logic sys_clk_i,            // 200 MHz
    input wire logic rst_i,                // Sync reset, high
    input wire logic clk_en_i,             // Freezes state when low
    input wire logic [3:0] avs_address_i,  // Word address
    input wire logic avs_read_i,           // Read strobe
    input wire logic avs_write_i,          // Write strobe
    input wire logic [31:0] avs_writedata_i, // Write data
    input wire logic [3:0] avs_byteenable_i, // Byte lanes
    output logic [31:0] avs_readdata_o,    // Read data
    output logic avs_waitrequest_o,        // Stall
    input wire logic strap_speed_lo_i,     // Strap pin, 0/1
    input wire logic strap_speed_lo_oe_i,  // Strap driven; low means pull level
    input wire logic strap_autoneg_i,      // Strap pin
    input wire logic strap_autoneg_oe_i,   // Strap driven
    input wire logic strap_duplex_i,       // Strap pin
    input wire logic strap_duplex_oe_i,    // Strap driven
    input wire logic autoneg_restarted_i,  // Autoneg restart done pulse
    input wire logic link_up_evt_i,        // Link up event
    input wire logic link_down_evt_i,      // Link fail event
    input wire logic [7:0] mac_txd_i,      // MAC transmit data
    input wire logic mac_tx_en_i,          // MAC transmit enable
    input wire logic [7:0] line_rxd_i,     // Converter receive data
    input wire logic line_rx_dv_i,         // Converter receive valid
    output logic [7:0] mac_rxd_o,          // Toward MAC
    output logic mac_rx_dv_o,              // Toward MAC
    output logic [7:0] line_txd_o,         // Toward converter
    output logic line_tx_en_o,             // Toward converter
    output logic [1:0] speed_o,            // Active speed code
    output logic full_duplex_o,            // Active duplex
    output logic autoneg_en_o,             // Autoneg enabled
    output logic soft_reset_busy_o         // Soft reset running
);
    typedef enum logic [1:0] {PBCU_IDLE, PBCU_RESET_RUN, PBCU_RESET_WAIT} pbcu_state_t;

    typedef struct packed {
        pbcu_state_t st;
        logic boot;
        logic loopback;
        logic speed_lo;
        logic speed_hi;
        logic autoneg_en;
        logic duplex;
        logic [3:0] strap_cap;
        logic link_up_lh;
        logic link_ok_ll;
        logic [20:0] cnt;
        logic [31:0] rdata;
        logic ack;
        logic waitreq;
        logic busy;
        logic [7:0] mac_rxd;
        logic mac_rx_dv;
        logic [7:0] line_txd;
        logic line_tx_en;
        logic [1:0] speed;
        logic fdx;
    } pbcu_reg_t;

    pbcu_reg_t r;
    pbcu_reg_t next_r;

    function automatic logic strap_level(input logic pin, input logic oe, input logic pull);
        strap_level = oe ? pin : pull;
    endfunction : strap_level

    logic [2:0] straps;
    logic [15:0] bmc_read;
    logic req;
    logic [1:0] forced_code;

    always_comb
    begin
        straps[0] = strap_level(strap_speed_lo_i, strap_speed_lo_oe_i,
            pbcu_pkg::STRAP_SPEED_LO_PULL);
        straps[1] = strap_level(strap_autoneg_i, strap_autoneg_oe_i,
            pbcu_pkg::STRAP_AUTONEG_PULL);
        straps[2] = strap_level(strap_duplex_i, strap_duplex_oe_i,
            pbcu_pkg::STRAP_DUPLEX_PULL);
        forced_code = {r.speed_hi, r.speed_lo};
        bmc_read = 16'h0000;
        bmc_read[pbcu_pkg::SOFT_RESET_BIT] = (r.st != PBCU_IDLE);
        bmc_read[pbcu_pkg::LOOPBACK_BIT] = r.loopback;
        bmc_read[pbcu_pkg::SPEED_LO_BIT] = r.speed_lo;
        bmc_read[pbcu_pkg::AUTONEG_EN_BIT] = r.autoneg_en;
        bmc_read[pbcu_pkg::DUPLEX_BIT] = r.duplex;
        bmc_read[pbcu_pkg::SPEED_HI_BIT] = r.speed_hi;
        req = (avs_read_i || avs_write_i) && !r.ack;
    end

    always_comb
    begin
        next_r = r;
        next_r.ack = 1'b0;
        // Straps caught one clock after release, never under reset
        if (r.boot)
        begin
            next_r.boot = 1'b0;
            next_r.speed_lo = straps[0];
            next_r.autoneg_en = straps[1];
            next_r.duplex = straps[2];
            next_r.strap_cap = {1'b0, straps};
        end
        // Sticky bits: event wins over the read that clears them
        if (req && avs_read_i && avs_address_i == pbcu_pkg::EVENT_STATUS_IDX)
        begin
            next_r.link_up_lh = 1'b0;
            next_r.link_ok_ll = 1'b1;
        end
        if (link_up_evt_i)
            next_r.link_up_lh = 1'b1;
        if (link_down_evt_i)
            next_r.link_ok_ll = 1'b0;
        if (req)
        begin
            next_r.ack = 1'b1;
            next_r.rdata = 32'h0000_0000;
            if (avs_read_i)
            begin
                unique case (avs_address_i)
                    pbcu_pkg::BMC_IDX: next_r.rdata = {16'h0000, bmc_read};
                    pbcu_pkg::MODE_STATUS_IDX: next_r.rdata = {24'h000000, r.strap_cap,
                        r.fdx, r.speed, r.autoneg_en};
                    pbcu_pkg::EVENT_STATUS_IDX: next_r.rdata = {30'h00000000,
                        r.link_ok_ll, r.link_up_lh};
                    default: next_r.rdata = 32'h0000_0000;
                endcase
            end
            else if (avs_address_i == pbcu_pkg::BMC_IDX && r.st == PBCU_IDLE && !r.boot)
            begin
                if (avs_byteenable_i[1])
                begin
                    next_r.loopback = avs_writedata_i[pbcu_pkg::LOOPBACK_BIT];
                    next_r.speed_lo = avs_writedata_i[pbcu_pkg::SPEED_LO_BIT];
                    next_r.autoneg_en = avs_writedata_i[pbcu_pkg::AUTONEG_EN_BIT];
                    next_r.duplex = avs_writedata_i[pbcu_pkg::DUPLEX_BIT];
                end
                if (avs_byteenable_i[0])
                    next_r.speed_hi = avs_writedata_i[pbcu_pkg::SPEED_HI_BIT];
                if (avs_byteenable_i[1] && avs_writedata_i[pbcu_pkg::SOFT_RESET_BIT])
                begin
                    // Control bits back to defaults, straps reapplied
                    next_r.loopback = 1'b0;
                    next_r.speed_hi = 1'b0;
                    next_r.speed_lo = r.strap_cap[0];
                    next_r.autoneg_en = r.strap_cap[1];
                    next_r.duplex = r.strap_cap[2];
                    next_r.cnt = 21'h000000;
                    next_r.st = PBCU_RESET_RUN;
                end
            end
        end
        unique case (r.st)
            PBCU_IDLE: ;
            PBCU_RESET_RUN:
            begin
                next_r.cnt = r.cnt + 21'h000001;
                if (r.cnt >= 21'(SOFT_RESET_LEN - 1))
                    next_r.st = PBCU_RESET_WAIT;
            end
            PBCU_RESET_WAIT:
            begin
                // Forced mode is entered at once; autoneg needs its restart
                if (!r.autoneg_en || autoneg_restarted_i)
                    next_r.st = PBCU_IDLE;
            end
        endcase
        // Speed and duplex apply only when autoneg is off
        if (!r.autoneg_en)
        begin
            next_r.speed = forced_code;
            next_r.fdx = r.duplex;
        end
        else
        begin
            next_r.speed = r.speed;
            next_r.fdx = r.fdx;
        end
        // Loop turns at the converter edge; line sees nothing meanwhile
        if (r.loopback)
        begin
            next_r.mac_rxd = mac_txd_i;
            next_r.mac_rx_dv = mac_tx_en_i;
            next_r.line_txd = 8'h00;
            next_r.line_tx_en = 1'b0;
        end
        else
        begin
            next_r.mac_rxd = line_rxd_i;
            next_r.mac_rx_dv = line_rx_dv_i;
            next_r.line_txd = mac_txd_i;
            next_r.line_tx_en = mac_tx_en_i;
        end
        // Handshake and busy kept as flops so no output has logic behind it
        next_r.waitreq = !next_r.ack;
        next_r.busy = (next_r.st != PBCU_IDLE);
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            r <= '0;
            r.st <= PBCU_IDLE;
            r.boot <= 1'b1;
            r.link_ok_ll <= 1'b1;
            r.waitreq <= 1'b1;
        end
        else if (clk_en_i)
            r <= next_r;
    end

    assign avs_readdata_o = r.rdata;
    assign avs_waitrequest_o = r.waitreq;
    assign speed_o = r.speed;
    assign full_duplex_o = r.fdx;
    assign autoneg_en_o = r.autoneg_en;
    assign soft_reset_busy_o = r.busy;
    assign mac_rxd_o = r.mac_rxd;
    assign mac_rx_dv_o = r.mac_rx_dv;
    assign line_txd_o = r.line_txd;
    assign line_tx_en_o = r.line_tx_en;

    AST_LH_HOLDS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && link_up_evt_i |=> r.link_up_lh)
        else $error("latched-high bit did not set");
    AST_LL_HOLDS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && link_down_evt_i |=> !r.link_ok_ll)
        else $error("latched-low bit did not clear");
    AST_SR_START: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && req && avs_write_i && avs_address_i == pbcu_pkg::BMC_IDX
        && r.st == PBCU_IDLE && !r.boot && avs_byteenable_i[1] && avs_writedata_i[15]
        |=> soft_reset_busy_o && !r.loopback && !r.speed_hi)
        else $error("soft reset did not start");
    AST_SR_END: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        r.st == PBCU_RESET_WAIT && clk_en_i && !r.autoneg_en |=> r.st == PBCU_IDLE)
        else $error("forced mode did not end reset");
    AST_SR_READ: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && req && avs_read_i && avs_address_i == pbcu_pkg::BMC_IDX
        && soft_reset_busy_o |=> avs_readdata_o[pbcu_pkg::SOFT_RESET_BIT])
        else $error("reset bit not reading one");
    AST_SR_CLEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && req && avs_read_i && avs_address_i == pbcu_pkg::BMC_IDX
        && !soft_reset_busy_o |=> !avs_readdata_o[pbcu_pkg::SOFT_RESET_BIT])
        else $error("reset bit reads one when idle");
    AST_SR_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        r.st == PBCU_RESET_RUN && r.cnt < 21'(SOFT_RESET_LEN - 1) |=> soft_reset_busy_o)
        else $error("soft reset ended early");
    AST_AN_END: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && r.st == PBCU_RESET_WAIT && autoneg_restarted_i |=> !soft_reset_busy_o)
        else $error("autoneg restart did not end reset");
    AST_LOOP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && r.loopback |=> mac_rxd_o == $past(mac_txd_i) && !line_tx_en_o)
        else $error("loopback path wrong");
    AST_FORCED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && !r.autoneg_en |=> speed_o == $past(forced_code))
        else $error("forced speed not applied");
    AST_AN_IGN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && r.autoneg_en |=> $stable(speed_o) && $stable(full_duplex_o))
        else $error("forced bits not ignored");
    AST_ANSWER: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && req |=> !avs_waitrequest_o)
        else $error("bus answer late");
    AST_RST_QUIET: assert property (@(posedge sys_clk_i)
        rst_i |=> avs_waitrequest_o && !soft_reset_busy_o && !r.loopback
        && r.link_ok_ll)
        else $error("reset state wrong");
    AST_BOOT_STRAP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && r.boot |=> r.speed_lo == $past(straps[0])
        && r.autoneg_en == $past(straps[1]) && r.duplex == $past(straps[2]))
        else $error("strap level not loaded");
    AST_LH_KEEP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        r.link_up_lh && !(req && avs_read_i && avs_address_i == pbcu_pkg::EVENT_STATUS_IDX)
        |=> r.link_up_lh)
        else $error("latched-high bit dropped before read");
    AST_LL_KEEP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !r.link_ok_ll && !(req && avs_read_i && avs_address_i == pbcu_pkg::EVENT_STATUS_IDX)
        |=> !r.link_ok_ll)
        else $error("latched-low bit rose before read");
    AST_REFUSE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        req && avs_write_i && soft_reset_busy_o |=> $stable(r.loopback) && $stable(r.autoneg_en))
        else $error("write taken during soft reset");
    COV_SR: cover property (@(posedge sys_clk_i) r.st == PBCU_RESET_WAIT ##1 r.st == PBCU_IDLE);
    COV_LOOP: cover property (@(posedge sys_clk_i) r.loopback && mac_tx_en_i);
    COV_1000: cover property (@(posedge sys_clk_i) speed_o == pbcu_pkg::SPEED_1000);
    COV_FORCED_END: cover property (@(posedge sys_clk_i)
        r.st == PBCU_RESET_WAIT && !r.autoneg_en ##1 !soft_reset_busy_o);
endmodule : pbcu_top
`default_nettype wire

// ==== rtl/pbcu_pkg.sv ====
package pbcu_pkg;
    // Register index; byte address is index times four on the bus
    localparam logic [3:0] BMC_IDX = 4'h0;
    localparam logic [3:0] MODE_STATUS_IDX = 4'h1;
    localparam logic [3:0] EVENT_STATUS_IDX = 4'h2;
    // Field positions in basic_mode_control
    localparam int SOFT_RESET_BIT = 15;
    localparam int LOOPBACK_BIT = 14;
    localparam int SPEED_LO_BIT = 13;
    localparam int AUTONEG_EN_BIT = 12;
    localparam int DUPLEX_BIT = 8;
    localparam int SPEED_HI_BIT = 6;
    // Forced speed codes {bit6, bit13}
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;
    localparam logic [1:0] SPEED_RSVD = 2'h3;
    // Strap types: undriven pin level
    localparam logic STRAP_SPEED_LO_PULL = 1'b0;
    localparam logic STRAP_AUTONEG_PULL = 1'b1;
    localparam logic STRAP_DUPLEX_PULL = 1'b1;
    // Soft reset duration
    localparam int SOFT_RESET_NS = 1200000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int SOFT_RESET_CYCLES = SOFT_RESET_NS / CLK_PERIOD_NS;
endpackage : pbcu_pkg

// ==== bench/pbcu_mac_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module pbcu_mac_model (
    input wire logic sys_clk_i,   // Bench clock
    input wire logic rst_i,       // Sync reset
    output logic [7:0] mac_txd_o, // MAC transmit byte
    output logic mac_tx_en_o,     // MAC transmit enable
    output logic [7:0] line_rxd_o, // Converter receive byte
    output logic line_rx_dv_o     // Converter receive valid
);
    logic [7:0] cnt;
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            cnt <= 8'h00;
        end
        else
        begin
            cnt <= cnt + 8'h01;
        end
    end
    // Unrelated streams, changing each cycle except line_rx_dv_o (every two), so a wrong path choice shows
    assign mac_txd_o = cnt ^ 8'h5a;
    assign mac_tx_en_o = cnt[0];
    assign line_rxd_o = {cnt[3:0], ~cnt[7:4]};
    assign line_rx_dv_o = ~cnt[1];
endmodule : pbcu_mac_model
`default_nettype wire

// ==== bench/phy_basic_control_upper_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module phy_basic_control_upper_bench;
    logic sys_clk_i, rst_i, avs_read_i, avs_write_i, mac_tx_en_i, line_rx_dv_i;
    logic autoneg_restarted_i, link_up_evt_i, link_down_evt_i;
    logic [3:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rdv;
    logic avs_waitrequest_o, mac_rx_dv_o, full_duplex_o, autoneg_en_o, soft_reset_busy_o;
    logic clk_en_i, strap_speed_lo_i, strap_speed_lo_oe_i, strap_autoneg_i, strap_autoneg_oe_i;
    logic strap_duplex_i, strap_duplex_oe_i, line_tx_en_o;
    logic [3:0] avs_byteenable_i;
    logic [7:0] mac_txd_i, line_rxd_i, mac_rxd_o, line_txd_o;
    logic [1:0] speed_o;
    int err_total = 0;
    int checks_done = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    pbcu_top #(.SOFT_RESET_LEN(8)) u_dut (.sys_clk_i, .rst_i, .clk_en_i, .avs_address_i,
        .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
        .avs_waitrequest_o, .strap_speed_lo_i, .strap_speed_lo_oe_i,
        .strap_autoneg_i, .strap_autoneg_oe_i, .strap_duplex_i,
        .strap_duplex_oe_i, .autoneg_restarted_i, .link_up_evt_i, .link_down_evt_i,
        .mac_txd_i, .mac_tx_en_i, .line_rxd_i, .line_rx_dv_i, .mac_rxd_o, .mac_rx_dv_o,
        .line_txd_o, .line_tx_en_o, .speed_o, .full_duplex_o, .autoneg_en_o,
        .soft_reset_busy_o);
    pbcu_mac_model u_mac (.sys_clk_i, .rst_i, .mac_txd_o(mac_txd_i), .mac_tx_en_o(mac_tx_en_i),
        .line_rxd_o(line_rxd_i), .line_rx_dv_o(line_rx_dv_i));
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        // Only the watchdog ends a wait that never gets its answer
        do
        begin
            @(posedge sys_clk_i);
        end
        while (avs_waitrequest_o !== 1'b0);
        rdv = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : bus
    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(nm, e, rdv)
    endtask : rd_chk
    task automatic t_defaults;
        rd_chk("reg0 default", 4'h0, 32'h0000_1000);
        `CHK("autoneg out", 1'b1, autoneg_en_o)
        rd_chk("unmapped", 4'h7, 32'h0);
    endtask : t_defaults
    task automatic t_speed;
        logic [1:0] c;
        for (int i = 2; i >= 0; i--)
        begin
            c = 2'(i);
            bus(1'b1, 4'h0, {16'h0, 2'b00, c[0], 4'h0, i[0], 1'b0, c[1], 6'h0});
            repeat (3) @(posedge sys_clk_i);
            `CHK("speed", c, speed_o)
            `CHK("duplex", i[0], full_duplex_o)
        end
        // Forced bits must be ignored once autoneg is back on
        bus(1'b1, 4'h0, 32'h0000_1140);
        repeat (3) @(posedge sys_clk_i);
        `CHK("speed frozen", 2'h0, speed_o)
        `CHK("duplex frozen", 1'b0, full_duplex_o)
        rd_chk("reg0 rw", 4'h0, 32'h0000_1140);
        // Lane 0 alone reaches bit 6 only
        avs_byteenable_i <= 4'h1;
        bus(1'b1, 4'h0, 32'h0000_0000);
        avs_byteenable_i <= 4'hf;
        rd_chk("reg0 lane0", 4'h0, 32'h0000_1100);
    endtask : t_speed
    task automatic t_loop;
        logic [7:0] p;
        logic [7:0] q;
        logic v;
        logic w;
        for (int k = 0; k < 2; k++)
        begin
            bus(1'b1, 4'h0, k == 0 ? 32'h0000_5000 : 32'h0000_1000);
            repeat (2) @(posedge sys_clk_i);
            p = k == 0 ? mac_txd_i : line_rxd_i;
            v = k == 0 ? mac_tx_en_i : line_rx_dv_i;
            // Line side stays silent while looped
            q = k == 0 ? 8'h00 : mac_txd_i;
            w = k == 0 ? 1'b0 : mac_tx_en_i;
            @(posedge sys_clk_i);
            `CHK("rx data", p, mac_rxd_o)
            `CHK("rx valid", v, mac_rx_dv_o)
            `CHK("tx data", q, line_txd_o)
            `CHK("tx valid", w, line_tx_en_o)
        end
    endtask : t_loop
    task automatic t_soft;
        int n;
        bus(1'b1, 4'h0, 32'h0000_6140);
        bus(1'b1, 4'h0, 32'h0000_8000);
        bus(1'b0, 4'h0, 32'h0);
        `CHK("reset bit", 1'b1, rdv[15])
        // Dropped while busy; would also end the wait at once if taken
        bus(1'b1, 4'h0, 32'h0000_4000);
        repeat (20) @(posedge sys_clk_i);
        `CHK("busy held", 1'b1, soft_reset_busy_o)
        autoneg_restarted_i <= 1'b1;
        @(posedge sys_clk_i);
        autoneg_restarted_i <= 1'b0;
        n = 0;
        while (soft_reset_busy_o !== 1'b0 && n < 20)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        `CHK("busy end", 1'b0, soft_reset_busy_o)
        rd_chk("reg0 after reset", 4'h0, 32'h0000_1000);
    endtask : t_soft
    task automatic t_events;
        link_up_evt_i <= 1'b1;
        @(posedge sys_clk_i);
        link_up_evt_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        rd_chk("up latched", 4'h2, 32'h3);
        rd_chk("up cleared", 4'h2, 32'h2);
        link_down_evt_i <= 1'b1;
        @(posedge sys_clk_i);
        link_down_evt_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        rd_chk("down latched", 4'h2, 32'h0);
        rd_chk("down rearmed", 4'h2, 32'h2);
        bus(1'b1, 4'h7, 32'hffff_ffff);
        rd_chk("unmapped wr", 4'h7, 32'h0);
        // An event while frozen must not be caught
        clk_en_i <= 1'b0;
        link_up_evt_i <= 1'b1;
        @(posedge sys_clk_i);
        link_up_evt_i <= 1'b0;
        clk_en_i <= 1'b1;
        rd_chk("frozen event", 4'h2, 32'h2);
    endtask : t_events
    task automatic t_straps;
        int n;
        // Driven high, driven low and undriven straps, then a mid-run reset
        strap_speed_lo_oe_i <= 1'b1;
        strap_autoneg_oe_i <= 1'b1;
        strap_duplex_oe_i <= 1'b0;
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        rd_chk("reg0 straps", 4'h0, 32'h0000_2100);
        rd_chk("mode status", 4'h1, 32'h0000_005a);
        `CHK("autoneg off", 1'b0, autoneg_en_o)
        `CHK("speed 100", pbcu_pkg::SPEED_100, speed_o)
        `CHK("full duplex", 1'b1, full_duplex_o)
        // Autoneg off: reset must end without any restart pulse
        bus(1'b1, 4'h0, 32'h0000_8000);
        n = 0;
        while (soft_reset_busy_o !== 1'b0 && n < 40)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        `CHK("forced end", 1'b0, soft_reset_busy_o)
        rd_chk("reg0 straps kept", 4'h0, 32'h0000_2100);
    endtask : t_straps
    task automatic end_sim;
        if (err_total == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    initial
    begin
        {sys_clk_i, avs_read_i, avs_write_i, autoneg_restarted_i} = 4'h0;
        {link_up_evt_i, link_down_evt_i, avs_address_i, avs_writedata_i} = 38'h0;
        clk_en_i = 1'b1;
        avs_byteenable_i = 4'hf;
        {strap_speed_lo_i, strap_speed_lo_oe_i, strap_autoneg_i, strap_autoneg_oe_i} = 4'h8;
        {strap_duplex_i, strap_duplex_oe_i} = 2'h1;
        rst_i = 1'b1;
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        t_defaults();
        t_speed();
        t_loop();
        t_soft();
        t_events();
        t_straps();
        end_sim();
    end
    // Whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge sys_clk_i);
        err_total++;
        end_sim();
    end
endmodule : phy_basic_control_upper_bench
`default_nettype wire
